// ### src/eeprom_i2c_slave.sv
// two-wire slave access logic of a 256 x 8 non-volatile memory
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RL1] data changes while clock is high are bus conditions, never data
// [RL2] master starts only on an idle bus, both lines high
// [RL3] data falling with clock high is start; expect address byte
// [RL4] data rising with clock high is stop; transfer ends
// [RL5] one clock pulse per bit, sampled while clock is high
// [RL6] eight bits then a ninth acknowledge slot clocked by master
// [RL7] master clocks at standard speed or slower; the bench master model clocks far faster
// [RL8] addressed receiving device acknowledges every byte
// [RL9] acknowledger holds data low for the whole ack clock high
// [RL10] master acknowledges each read byte except the last
// [RL11] no master ack ends a read; device releases data line
// [RL12] address byte: type code, three straps, direction; respond on match
// [RL13] address byte follows start; lsb one reads, zero writes
// [RL14] write sends word address then data, each acknowledged
// [RL15] byte mode: at most seven data bytes per transfer
// [RL16] stop after write starts timed cycle, ten ms per byte
// [RL17] during the cycle inputs ignored and address not acknowledged
// [RL18] page mode: eight bytes acked, block erased, then written
// [RL19] page mode increments only the three low address bits
// [RL20] a ninth page byte is not acked; whole transfer discarded
// [RL21] current address, random and sequential reads supported
// [RL22] word address increments after each byte, wrapping 255 to 0
// [RL23] random read: address-only write, then repeated start reading
// [RL24] current address read uses and then advances held address
module eeprom_i2c_slave
    import eeprom_pkg::*;
#(
    parameter logic [3:0]  DEV_TYPE        = 4'h6, // arbitrary value
    parameter int unsigned BYTE_EW_CYCLES  = BYTE_EW_CYC,
    parameter int unsigned ERASE_CYCLES    = ERASE_CYC,
    parameter int unsigned PAGE_BYTE_CYCLES = PAGE_BYTE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic strap_select_bit_zero,
    input  wire logic strap_select_bit_one,
    input  wire logic strap_select_bit_two,
    input  wire logic page_mode,
    output logic      write_busy
);
    logic [7:0]   mem [MEM_DEPTH];
    logic         scl_q;
    logic         sda_q;
    link_state_t  st;
    link_state_t  next_st;
    ew_state_t    eng;
    logic [3:0]   cnt;
    logic [3:0]   wcnt;
    logic         ack_phase;
    logic         acked;
    logic         mack_n;
    logic         sda_low;
    logic         discard;
    logic         commit;
    logic         ew_page;
    logic [7:0]   sh;
    logic [7:0]   tx;
    logic [7:0]   addr;
    logic [31:0]  timer;
    logic         fifo_in_ready;
    logic         fifo_out_valid;
    logic         fifo_out_ready;
    logic [15:0]  fifo_out_data;

    // bus conditions, pins are synchronous to sys_clk
    wire scl_rise  = scl_in & ~scl_q;
    wire scl_fall  = ~scl_in & scl_q;
    wire start_det = scl_in & scl_q & sda_q & ~sda_in; // RL3 RL1
    wire stop_det  = scl_in & scl_q & ~sda_q & sda_in; // RL4 RL1
    wire busy      = (eng != E_IDLE);
    wire [2:0] straps = {strap_select_bit_two, strap_select_bit_one,
                         strap_select_bit_zero};

    // slot boundaries
    wire ack_start = scl_fall & ~ack_phase & (cnt == ACK_SLOT); // RL6
    wire byte_end  = scl_fall & ack_phase;
    wire rd_bit    = scl_fall & ~ack_phase & (cnt != ACK_SLOT) & (cnt != 4'h0)
                     & (st == ST_RD);

    // address match and acknowledge decision
    wire dev_hit  = (sh[7:4] == DEV_TYPE) & (sh[3:1] == straps) & ~busy; // RL12 RL17
    wire [3:0] wr_lim = page_mode ? PAGE_MAX : BYTE_MAX;
    wire wd_ok    = fifo_in_ready & (wcnt < wr_lim) & ~discard; // RL20
    wire give_ack = ((st == ST_DEV) & dev_hit) | (st == ST_WORD)
                    | ((st == ST_WD) & wd_ok); // RL8 RL14 RL18
    wire push     = ack_start & (st == ST_WD) & wd_ok;
    wire load_rd  = byte_end & (((st == ST_DEV) & acked & sh[0])
                    | ((st == ST_RD) & ~mack_n)); // RL21 RL24
    wire [7:0] next_addr_w = page_mode ? {addr[7:3], addr[2:0] + 3'h1}
                             : addr + 8'h01; // RL19 RL22
    // a write that never saw a stop is not programmed
    wire flush    = ((stop_det | start_det) & (st == ST_WD) & discard)
                    | (start_det & ~busy & (st == ST_WD) & ~discard
                       & (wcnt != 4'h0));

    always_comb begin
        next_st = st;
        unique case (st)
            ST_IDLE: next_st = ST_IDLE;
            ST_DEV:  next_st = ~acked ? ST_IDLE : (sh[0] ? ST_RD : ST_WORD); // RL13
            ST_WORD: next_st = ST_WD;
            ST_WD:   next_st = ST_WD;
            ST_RD:   next_st = mack_n ? ST_IDLE : ST_RD; // RL11
            default: next_st = ST_IDLE;
        endcase
    end

    assign sda_out    = 1'b0;
    assign sda_oe     = sda_low;
    assign write_busy = busy;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            commit <= 1'b0;
        end else begin
            commit <= stop_det & (st == ST_WD) & (wcnt != 4'h0) & ~discard; // RL16
        end
    end

    // link side; starts are not even seen while programming
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st        <= ST_IDLE;
            cnt       <= 4'h0;
            wcnt      <= 4'h0;
            ack_phase <= 1'b0;
            acked     <= 1'b0;
            mack_n    <= 1'b1;
            sda_low   <= 1'b0;
            discard   <= 1'b0;
            sh        <= 8'h00;
            tx        <= 8'h00;
            addr      <= 8'h00;
        end else if (start_det & ~busy) begin // RL17
            st        <= ST_DEV; // RL3
            cnt       <= 4'h0;
            wcnt      <= 4'h0;
            ack_phase <= 1'b0;
            sda_low   <= 1'b0;
            discard   <= 1'b0;
        end else if (stop_det) begin
            st        <= ST_IDLE; // RL4
            ack_phase <= 1'b0;
            sda_low   <= 1'b0;
        end else if (st != ST_IDLE) begin
            if (scl_rise & ~ack_phase) begin
                sh  <= {sh[6:0], sda_in}; // RL5
                cnt <= cnt + 4'h1;
            end
            if (scl_rise & ack_phase) begin
                mack_n <= sda_in;
            end
            if (ack_start) begin
                ack_phase <= 1'b1;
                acked     <= give_ack;
                sda_low   <= give_ack; // RL9
                if (push) begin
                    addr <= next_addr_w;
                    wcnt <= wcnt + 4'h1;
                end
                if ((st == ST_WD) & ~give_ack) begin
                    discard <= 1'b1; // RL20
                end
            end else if (rd_bit) begin
                sda_low <= ~tx[6];
                tx      <= {tx[6:0], 1'b0};
            end
            if (byte_end) begin
                ack_phase <= 1'b0;
                cnt       <= 4'h0;
                sda_low   <= 1'b0;
                st        <= next_st;
                if (st == ST_WORD) begin
                    addr <= sh; // RL14
                end
                if (load_rd) begin
                    tx      <= mem[addr];
                    sda_low <= ~mem[addr][7];
                    addr    <= addr + 8'h01; // RL22
                end
            end
        end
    end

    // programming engine, fed only after a clean stop
    assign fifo_out_ready = (eng == E_PROG) & fifo_out_valid & (timer == 32'h0);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            eng     <= E_IDLE;
            ew_page <= 1'b0;
            timer   <= 32'h0;
        end else begin
            unique case (eng)
                E_IDLE: begin
                    if (commit) begin
                        ew_page <= page_mode;
                        eng     <= page_mode ? E_ERASE : E_PROG; // RL18
                        timer   <= page_mode ? ERASE_CYCLES - 1
                                   : BYTE_EW_CYCLES - 1; // RL16
                    end
                end
                E_ERASE: begin
                    if (timer == 32'h0) begin
                        eng   <= E_PROG;
                        timer <= PAGE_BYTE_CYCLES - 1;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                E_PROG: begin
                    if (~fifo_out_valid) begin
                        eng <= E_IDLE;
                    end else if (timer == 32'h0) begin
                        timer <= ew_page ? PAGE_BYTE_CYCLES - 1
                                 : BYTE_EW_CYCLES - 1;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: eng <= E_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (fifo_out_ready) begin
            mem[fifo_out_data[15:8]] <= fifo_out_data[7:0];
        end
    end

    // buffer between bus and programming engine; a full fifo refuses the ack
    ew_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({addr, sh}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    sequence s_dev_ack;
        ack_start && (st == ST_DEV);
    endsequence

    sequence s_wd_slot;
        ack_start && (st == ST_WD);
    endsequence

    a_sda_stable: assert property (@(posedge sys_clk) disable iff (srst) // RL1
        (scl_in && scl_q) |-> $stable(sda_oe))
        else $error("device changed data line while clock high");

    a_start_addr: assert property (@(posedge sys_clk) disable iff (srst) // RL3
        (start_det && !busy) |=> (st == ST_DEV) && (cnt == 4'h0))
        else $error("start did not arm address reception");

    a_stop_idle: assert property (@(posedge sys_clk) disable iff (srst) // RL4
        (stop_det && !(start_det && !busy)) |=> (st == ST_IDLE) && !sda_oe)
        else $error("stop did not end transfer");

    a_bit_count: assert property (@(posedge sys_clk) disable iff (srst) // RL5
        (scl_rise && !ack_phase && (st != ST_IDLE) && !start_det && !stop_det)
        |=> cnt == $past(cnt) + 4'h1)
        else $error("bit count did not advance");

    a_match_ack: assert property (@(posedge sys_clk) disable iff (srst) // RL12
        (s_dev_ack and (dev_hit == 1'b1)) |=> sda_oe)
        else $error("matching address not acknowledged");

    a_miss_nack: assert property (@(posedge sys_clk) disable iff (srst) // RL8
        (s_dev_ack and (sh[7:4] != DEV_TYPE)) |=> !sda_oe)
        else $error("foreign address acknowledged");

    a_busy_quiet: assert property (@(posedge sys_clk) disable iff (srst) // RL17
        busy |-> !sda_oe)
        else $error("device drove bus during programming");

    a_ninth_nack: assert property (@(posedge sys_clk) disable iff (srst) // RL20
        (s_wd_slot and (page_mode && wcnt == PAGE_MAX)) |=> !sda_oe ##0 discard)
        else $error("ninth page byte accepted");

    a_page_wrap: assert property (@(posedge sys_clk) disable iff (srst) // RL19
        (push && page_mode) |=> addr[7:3] == $past(addr[7:3]))
        else $error("page write moved upper address bits");

    a_read_inc: assert property (@(posedge sys_clk) disable iff (srst) // RL22
        load_rd |=> addr == $past(addr) + 8'h01)
        else $error("read did not advance word address");

    a_read_release: assert property (@(posedge sys_clk) disable iff (srst) // RL11
        (ack_phase && st == ST_RD) |-> !sda_low)
        else $error("device held data during master ack slot");

    a_commit_busy: assert property (@(posedge sys_clk) disable iff (srst) // RL16
        commit |=> busy [*3])
        else $error("stop after write did not start timed cycle");

    a_erase_first: assert property (@(posedge sys_clk) disable iff (srst) // RL18
        (commit && page_mode) |=> (eng == E_ERASE) && (timer == ERASE_CYCLES - 1))
        else $error("page write skipped block erase");
endmodule
`default_nettype wire

// ### src/eeprom_pkg.sv
// shared constants and types for the two-wire memory slave
package eeprom_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned BYTE_EW_US    = 10_000;
    localparam int unsigned PAGE_ERASE_US = 3_500;
    localparam int unsigned PAGE_PROG_US  = 28_000;
    localparam int unsigned PAGE_LEN      = 8;
    localparam int unsigned BYTE_EW_CYC   = BYTE_EW_US * CYC_PER_US;
    localparam int unsigned ERASE_CYC     = PAGE_ERASE_US * CYC_PER_US;
    localparam int unsigned PAGE_BYTE_CYC = PAGE_PROG_US * CYC_PER_US / PAGE_LEN;
    localparam int unsigned MEM_DEPTH     = 256;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam int unsigned FIFO_WIDTH    = 16;
    localparam logic [3:0]  PAGE_MAX      = 4'h8;
    localparam logic [3:0]  BYTE_MAX      = 4'h7;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DEV  = 5'h02,
        ST_WORD = 5'h04,
        ST_WD   = 5'h08,
        ST_RD   = 5'h10
    } link_state_t;

    typedef enum logic [2:0] {
        E_IDLE  = 3'h1,
        E_ERASE = 3'h2,
        E_PROG  = 3'h4
    } ew_state_t;
endpackage

// ### src/ew_fifo.sv
// synchronous fifo holding address/data pairs awaiting programming
`timescale 1ns/10ps
`default_nettype none
module ew_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    wire full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = in_valid & in_ready;
    wire do_rd = out_valid & out_ready;

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = store[rd_ptr[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // flush drops everything, used when a transfer is abandoned
    always_ff @(posedge sys_clk) begin
        if (srst | flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/eeprom_i2c_slave_tb.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/10ps
`default_nettype none
module eeprom_i2c_slave_tb;
    import eeprom_pkg::*;
    localparam logic [3:0] DEV = 4'h5; // arbitrary type code
    localparam int BEW = 400;
    localparam int ERS = 200;
    localparam int PGB = 100;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       page_mode = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [7:0] mem_m [256];
    logic [7:0] cur;
    int         miscompares = 0;
    int         check_count = 0;
    int         run = 0;
    int         last_run = 0;
    wire        scl;
    wire        sda_low;
    wire        sda_out;
    wire        sda_oe;
    wire        write_busy;
    wire        sda_line = ~(sda_low | (sda_oe & ~sda_out));

    always #5 sys_clk = ~sys_clk;

    i2c_master_model m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    eeprom_i2c_slave #(.DEV_TYPE(DEV), .BYTE_EW_CYCLES(BEW), .ERASE_CYCLES(ERS),
                       .PAGE_BYTE_CYCLES(PGB)) dut (
        .sys_clk(sys_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit_zero(strap[0]),
        .strap_select_bit_one(strap[1]), .strap_select_bit_two(strap[2]),
        .page_mode(page_mode), .write_busy(write_busy)
    );

    // length of the most recent busy run, for timing checks
    always @(posedge sys_clk) begin
        if (write_busy === 1'b1) run <= run + 1;
        else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [7:0] dev_byte(input logic rd);
        return {DEV, strap, rd};
    endfunction

    function automatic logic [7:0] next_addr(input logic pm, input logic [7:0] wa, input int i);
        return pm ? {wa[7:3], wa[2:0] + 3'(i)} : wa + 8'(i);
    endfunction

    task automatic wait_idle();
        int k;
        for (k = 0; k < 8000 && write_busy !== 1'b0; k++) @(negedge sys_clk);
        if (k == 8000) begin
            check("busy timeout", 1, 0);
            wrap_up();
        end
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic write_seq(input logic pm, input logic [7:0] wa, input int n);
        logic       ack;
        logic [7:0] d;
        int         lim;
        lim = pm ? 8 : 7;
        page_mode = pm;
        m.start_cond();
        m.byte_out(dev_byte(1'b0), ack);
        check("dev ack", ack, 0);
        m.byte_out(wa, ack);
        check("word ack", ack, 0);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            m.byte_out(d, ack);
            check("data ack", ack, 16'(i >= lim));
            if (n <= lim) mem_m[next_addr(pm, wa, i)] = d;
        end
        m.stop_cond();
        if (n > lim) begin
            check("busy after discard", write_busy, 0);
            return;
        end
        check("busy", write_busy, 1);
        // an access attempt while programming must go unanswered
        m.start_cond();
        m.byte_out(dev_byte(1'b0), ack);
        check("busy nack", ack, 1);
        m.stop_cond();
        wait_idle();
        lim = pm ? ERS + n * PGB : n * BEW;
        check("busy length", 16'(last_run >= lim && last_run <= lim + 4), 1);
    endtask

    task automatic read_seq(input logic rnd, input logic [7:0] wa, input int n);
        logic       ack;
        logic [7:0] d;
        if (rnd) begin
            m.start_cond();
            m.byte_out(dev_byte(1'b0), ack);
            m.byte_out(wa, ack);
            check("addr ack", ack, 0);
            cur = wa;
        end
        m.start_cond();
        m.byte_out(dev_byte(1'b1), ack);
        check("read dev ack", ack, 0);
        for (int i = 0; i < n; i++) begin
            m.byte_in(i == n - 1, d);
            check("read data", d, mem_m[cur]);
            cur++;
        end
        check("released", sda_oe, 0);
        m.stop_cond();
    endtask

    initial begin
        logic       ack;
        logic [7:0] wa;
        int         n;
        void'($urandom(74539));
        strap = 3'($urandom);
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        check("reset oe", sda_oe, 0);
        check("reset busy", write_busy, 0);
        check("pull value", sda_out, 0);
        write_seq(1'b1, 8'h05, 8);
        write_seq(1'b0, 8'hfc, 7);
        read_seq(1'b1, 8'hfc, 9);
        read_seq(1'b0, 8'h00, 1);
        write_seq(1'b1, 8'h00, 9);
        // an eighth byte in byte mode is refused and the transfer dropped
        write_seq(1'b0, 8'h10, 8);
        read_seq(1'b1, 8'h00, 8);
        // each strap bit and the type code wrong in turn
        for (int k = 0; k < 4; k++) begin
            m.start_cond();
            m.byte_out(dev_byte(1'b0) ^ ((k == 3) ? 8'h80 : (8'h02 << k)), ack);
            check("mismatch nack", ack, 1);
            m.stop_cond();
        end
        for (int r = 0; r < 3; r++) begin
            wa = 8'($urandom);
            n = 1 + int'($urandom % 7);
            write_seq(1'b0, wa, n);
            read_seq(1'b1, wa, n);
        end
        wrap_up();
    end
endmodule
`default_nettype wire

// ### test/i2c_master_model.sv
// two-wire bus master model: drives the clock and pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(
    // quarter bit in sys_clk cycles; far above standard speed to keep runs short,
    // the slave only needs each level to stand for two samples
    parameter int Q = 4
) (
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick();
        repeat (Q) @(negedge sys_clk);
    endtask

    // data only moves a quarter bit after the clock fell, never while it is high
    task automatic put_bit(input logic b);
        sda_low = ~b;
        tick();
        scl = 1'b1;
        tick();
        tick();
        scl = 1'b0;
        tick();
    endtask

    // sampled early and late in the high phase: low only if low throughout
    task automatic get_bit(output logic b);
        logic s;
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        s = sda_line;
        tick();
        b = s | sda_line;
        scl = 1'b0;
        tick();
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
        tick();
    endtask

    task automatic byte_out(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(ack);
    endtask

    task automatic byte_in(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule
`default_nettype wire
